// File: core/dud_defs.svh
/*
 * Register indices, field positions, reset values and counts for the
 * dual-channel upset detector. Assumes a 32-bit APB slave whose byte address
 * is four times the register index.
 */
`ifndef DUD_DEFS_SVH
`define DUD_DEFS_SVH

`define DUD_IDX_LINK_EN 10'h200
`define DUD_IDX_MODE 10'h201
`define DUD_IDX_CTRL 10'h300
`define DUD_IDX_OSC_SEL 10'h301
`define DUD_IDX_ALARM_STATUS 10'h302
`define DUD_IDX_ALARM_MASK 10'h303
`define DUD_IDX_ALM_SUMMARY 10'h304

`define DUD_RST_LINK_EN 1'h1
`define DUD_RST_MODE 8'h02
`define DUD_RST_CTRL 6'h00
`define DUD_RST_OSC_SEL 4'h0
`define DUD_RST_MASK 2'h0

`define DUD_CTRL_PD_A 0
`define DUD_CTRL_PD_B 1
`define DUD_CTRL_GLOBAL_PD 2
`define DUD_CTRL_SYNC_SRC 3
`define DUD_CTRL_SEL_MODE 4
`define DUD_CTRL_CAL_SEL 5
`define DUD_CTRL_W 6

`define DUD_ALM_OSC 0
`define DUD_ALM_CLK 1
`define DUD_ALM_W 2
`define DUD_STAT_SYNCED 4

`define DUD_MODE_DDC_LO 8'h0A
`define DUD_MODE_DDC_HI 8'h0F

`endif

// File: core/dud_pkg.sv
/*
 * Types shared by the upset detector files. Assumes nothing of its
 * surroundings.
 */
package dud_pkg;
    typedef enum logic [1:0] {
        DUD_SYNC_OFF,
        DUD_SYNC_WAIT,
        DUD_SYNC_DONE
    } dud_sync_e;

    typedef logic [9:0] dud_idx_t;
endpackage

// File: core/dud_cmp.sv
/*
 * Sticky mismatch detector: compares two equal-width values whenever
 * sample_en is high and latches any difference until cleared.
 * Assumes an asynchronously asserted active-low reset from the top.
 */
`timescale 1ns/100ps
module dud_cmp #(
    parameter int W = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_en,
    input wire logic [W-1:0] val_a,
    input wire logic [W-1:0] val_b,
    input wire logic clear,
    output logic flag
);
    logic flag_q;
    logic flag_d;

    always_comb begin
        flag_d = flag_q;
        if (clear) begin
            flag_d = 1'b0;
        end
        // A mismatch in the clearing cycle wins over the clear
        if (sample_en && (val_a != val_b)) begin
            flag_d = 1'b1; // R15
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

// File: core/dud_top.sv
/*
 * Dual-channel upset detector: lockstep comparison of the channel A and B
 * oscillator phase accumulators and internal clock states, sticky alarms,
 * alarm mask and summary, oscillator sync sequencing, APB register file.
 * Assumes the datapath presents both channels' accumulators and clock
 * states synchronous to sys_clk, which is the device clock.
 */
// Design decision made here: the APB interface to the registers.
// Summary of operation
// R01: Compare all A and B oscillator accumulators each cycle; any difference sets osc alarm.
// R02: Osc alarm stays set until software writes one to it.
// R03: Software programs matching A and B phase and frequency words per index.
// R04: Channel B may pick another oscillator index than A; detection stays on.
// R05: Osc detection counts only after sync from system reference or lane alignment start.
// R06: Software follows the link-off, configure, link-on, sync, clear, monitor order.
// R07: After changing words while running, software repeats sync, clear, monitor.
// R08: After global power-down, software repeats sync, clear, monitor.
// R09: Compare A and B internal clocks every half-rate cycle; difference sets clock alarm (code: only with link on, both channels up, no global power-down).
// R10: Clock alarm stays set until software writes one to it.
// R11: Leaving global power-down may set clock alarm; software clears it.
// R12: Oscillators never run in single-channel interleaved mode.
// R13: Each alarm sets its sticky status bit; unmasked ones show in the summary.
// R14: Calibration status output shows alarms when its selector picks them.
// R15: Writing zero leaves alarm bits; a mismatch during a clear keeps the bit.
`timescale 1ns/100ps
`include "dud_defs.svh"
module dud_top #(
    parameter int NOSC = 4,
    parameter int ACC_W = 32,
    parameter int CLK_W = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NOSC*ACC_W-1:0] chan_a_phase_acc,
    input wire logic [NOSC*ACC_W-1:0] chan_b_phase_acc,
    input wire logic [CLK_W-1:0] chan_a_clk_state,
    input wire logic [CLK_W-1:0] chan_b_clk_state,
    input wire logic sysref_pulse,
    input wire logic ilas_start,
    input wire logic pd_pin,
    input wire logic des_mode,
    input wire logic cal_done,
    input wire logic [1:0] chan_a_osc_select_pins,
    input wire logic [1:0] chan_b_osc_select_pins,
    output logic [1:0] chan_a_osc_sel,
    output logic [1:0] chan_b_osc_sel,
    output logic osc_run,
    output logic osc_sync_pulse,
    output logic serial_link_enable,
    output logic [7:0] serial_format_mode,
    output logic chan_a_power_down,
    output logic chan_b_power_down,
    output logic global_power_down,
    output logic alarm_irq,
    output logic cal_status_output
);
    generate
        if (NOSC < 1 || NOSC > 4) begin : g_bad_nosc
            $error("NOSC must be 1 to 4 for a two-bit select");
        end
        if (ACC_W < 1 || CLK_W < 1) begin : g_bad_width
            $error("Accumulator and clock widths must be positive");
        end
    endgenerate

    // Reset release through two flops
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Register state
    logic link_en_q;
    logic link_en_d;
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [`DUD_CTRL_W-1:0] ctrl_q;
    logic [`DUD_CTRL_W-1:0] ctrl_d;
    logic [3:0] osc_sel_reg_q;
    logic [3:0] osc_sel_reg_d;
    logic [`DUD_ALM_W-1:0] mask_q;
    logic [`DUD_ALM_W-1:0] mask_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    dud_pkg::dud_sync_e sync_q;
    dud_pkg::dud_sync_e sync_d;

    logic [`DUD_ALM_W-1:0] alarm_status_bits;
    logic [`DUD_ALM_W-1:0] alm_clear;
    logic alm_summary;
    dud_pkg::dud_idx_t idx;
    logic setup_ph;
    logic wr_acc;
    logic mapped;

    assign idx = paddr[11:2];
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    always_comb begin
        mapped = 1'b1;
        if (idx == `DUD_IDX_LINK_EN) begin
            mapped = 1'b1;
        end else if (idx == `DUD_IDX_MODE) begin
            mapped = 1'b1;
        end else if (idx == `DUD_IDX_CTRL) begin
            mapped = 1'b1;
        end else if (idx == `DUD_IDX_OSC_SEL) begin
            mapped = 1'b1;
        end else if (idx == `DUD_IDX_ALARM_STATUS) begin
            mapped = 1'b1;
        end else if (idx == `DUD_IDX_ALARM_MASK) begin
            mapped = 1'b1;
        end else if (idx == `DUD_IDX_ALM_SUMMARY) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Zero-wait slave; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        link_en_d = link_en_q;
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        osc_sel_reg_d = osc_sel_reg_q;
        mask_d = mask_q;
        alm_clear = '0;
        if (wr_acc) begin
            if (idx == `DUD_IDX_LINK_EN) begin
                link_en_d = pwdata[0];
            end else if (idx == `DUD_IDX_MODE) begin
                mode_d = pwdata[7:0];
            end else if (idx == `DUD_IDX_CTRL) begin
                ctrl_d = pwdata[`DUD_CTRL_W-1:0];
            end else if (idx == `DUD_IDX_OSC_SEL) begin
                osc_sel_reg_d = pwdata[3:0];
            end else if (idx == `DUD_IDX_ALARM_STATUS) begin
                alm_clear = pwdata[`DUD_ALM_W-1:0]; // R02 R10 R11 R15
            end else if (idx == `DUD_IDX_ALARM_MASK) begin
                mask_d = pwdata[`DUD_ALM_W-1:0];
            end
        end
    end

    always_comb begin
        prdata_d = prdata_q;
        if (setup_ph && !pwrite) begin
            prdata_d = 32'h00000000;
            if (idx == `DUD_IDX_LINK_EN) begin
                prdata_d[0] = link_en_q;
            end else if (idx == `DUD_IDX_MODE) begin
                prdata_d[7:0] = mode_q;
            end else if (idx == `DUD_IDX_CTRL) begin
                prdata_d[`DUD_CTRL_W-1:0] = ctrl_q;
            end else if (idx == `DUD_IDX_OSC_SEL) begin
                prdata_d[3:0] = osc_sel_reg_q;
            end else if (idx == `DUD_IDX_ALARM_STATUS) begin
                prdata_d[`DUD_ALM_W-1:0] = alarm_status_bits; // R13
                prdata_d[`DUD_STAT_SYNCED] = (sync_q == dud_pkg::DUD_SYNC_DONE);
            end else if (idx == `DUD_IDX_ALARM_MASK) begin
                prdata_d[`DUD_ALM_W-1:0] = mask_q;
            end else if (idx == `DUD_IDX_ALM_SUMMARY) begin
                prdata_d[0] = alm_summary; // R13
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_en_q <= `DUD_RST_LINK_EN;
            mode_q <= `DUD_RST_MODE;
            ctrl_q <= `DUD_RST_CTRL;
            osc_sel_reg_q <= `DUD_RST_OSC_SEL;
            mask_q <= `DUD_RST_MASK;
            prdata_q <= 32'h00000000;
        end else begin
            link_en_q <= link_en_d;
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
            osc_sel_reg_q <= osc_sel_reg_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

    // Mode and power decode
    logic ddc_mode;
    logic pd_any_global;
    logic both_chan_up;
    logic osc_active;
    assign ddc_mode = (mode_q >= `DUD_MODE_DDC_LO) && (mode_q <= `DUD_MODE_DDC_HI);
    assign pd_any_global = ctrl_q[`DUD_CTRL_GLOBAL_PD] || pd_pin;
    assign both_chan_up = !ctrl_q[`DUD_CTRL_PD_A] && !ctrl_q[`DUD_CTRL_PD_B];
    // Interleaved mode blocks the down-converters whatever the mode number says
    assign osc_active = ddc_mode && !des_mode && both_chan_up && !pd_any_global; // R12
    assign osc_run = osc_active; // R12

    // Oscillator sync sequencing; any stop of the oscillators forces a fresh sync
    logic sync_pulse_q;
    logic sync_pulse_d;
    logic sync_evt;
    assign sync_evt = ctrl_q[`DUD_CTRL_SYNC_SRC] ? ilas_start : sysref_pulse; // R05

    always_comb begin
        sync_d = sync_q;
        sync_pulse_d = 1'b0;
        case (sync_q)
            dud_pkg::DUD_SYNC_OFF: begin
                if (osc_active && link_en_q) begin
                    sync_d = dud_pkg::DUD_SYNC_WAIT;
                end
            end
            dud_pkg::DUD_SYNC_WAIT: begin
                if (!osc_active || !link_en_q) begin
                    sync_d = dud_pkg::DUD_SYNC_OFF;
                end else if (sync_evt) begin
                    sync_d = dud_pkg::DUD_SYNC_DONE; // R05
                    sync_pulse_d = 1'b1;
                end
            end
            dud_pkg::DUD_SYNC_DONE: begin
                // Leaving via power-down drops sync so the host must redo it
                if (!osc_active || !link_en_q) begin
                    sync_d = dud_pkg::DUD_SYNC_OFF; // R08
                end
            end
            default: begin
                sync_d = dud_pkg::DUD_SYNC_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= dud_pkg::DUD_SYNC_OFF;
            sync_pulse_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            sync_pulse_q <= sync_pulse_d;
        end
    end

    assign osc_sync_pulse = sync_pulse_q;

    // Oscillator index selection: register or pins, each channel its own
    logic [1:0] sel_a_q;
    logic [1:0] sel_a_d;
    logic [1:0] sel_b_q;
    logic [1:0] sel_b_d;

    always_comb begin
        if (ctrl_q[`DUD_CTRL_SEL_MODE]) begin
            sel_a_d = osc_sel_reg_q[1:0];
            sel_b_d = osc_sel_reg_q[3:2]; // R04
        end else begin
            sel_a_d = chan_a_osc_select_pins;
            sel_b_d = chan_b_osc_select_pins; // R04
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_a_q <= 2'h0;
            sel_b_q <= 2'h0;
        end else begin
            sel_a_q <= sel_a_d;
            sel_b_q <= sel_b_d;
        end
    end

    assign chan_a_osc_sel = sel_a_q;
    assign chan_b_osc_sel = sel_b_q;

    // Half-rate enable for the clock comparison
    logic half_en_q;
    logic half_en_d;
    assign half_en_d = !half_en_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_en_q <= 1'b0;
        end else begin
            half_en_q <= half_en_d;
        end
    end

    // The whole accumulator bank is compared, not only the selected one,
    // so a different channel B index does not blind the check
    logic osc_cmp_en;
    logic clk_cmp_en;
    assign osc_cmp_en = (sync_q == dud_pkg::DUD_SYNC_DONE); // R05
    assign clk_cmp_en = half_en_q && link_en_q && both_chan_up && !pd_any_global; // R09

    dud_cmp #(
        .W(NOSC*ACC_W)
    ) u_osc_cmp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_en(osc_cmp_en),
        .val_a(chan_a_phase_acc),
        .val_b(chan_b_phase_acc),
        .clear(alm_clear[`DUD_ALM_OSC]),
        .flag(alarm_status_bits[`DUD_ALM_OSC])
    ); // R01 R02

    dud_cmp #(
        .W(CLK_W)
    ) u_clk_cmp (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_en(clk_cmp_en),
        .val_a(chan_a_clk_state),
        .val_b(chan_b_clk_state),
        .clear(alm_clear[`DUD_ALM_CLK]),
        .flag(alarm_status_bits[`DUD_ALM_CLK])
    ); // R09 R10

    // Summary, interrupt and calibration status pin
    logic irq_q;
    logic irq_d;
    logic cal_q;
    logic cal_d;
    assign alm_summary = |(alarm_status_bits & ~mask_q); // R13

    always_comb begin
        irq_d = alm_summary;
        cal_d = ctrl_q[`DUD_CTRL_CAL_SEL] ? alm_summary : cal_done; // R14
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            cal_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            cal_q <= cal_d;
        end
    end

    assign alarm_irq = irq_q;
    assign cal_status_output = cal_q;

    assign serial_link_enable = link_en_q;
    assign serial_format_mode = mode_q;
    assign chan_a_power_down = ctrl_q[`DUD_CTRL_PD_A];
    assign chan_b_power_down = ctrl_q[`DUD_CTRL_PD_B];
    assign global_power_down = pd_any_global;
endmodule

// File: verif/dud_upset_monitor.sv
/*
 * Port-level assertions for the upset detector.
 * Assumes it is bound to dud_top and that sys_clk is the only clock.
 */
`timescale 1ns/100ps
module dud_upset_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic sysref_pulse,
    input wire logic ilas_start,
    input wire logic pd_pin,
    input wire logic des_mode,
    input wire logic osc_run,
    input wire logic osc_sync_pulse,
    input wire logic serial_link_enable,
    input wire logic global_power_down,
    input wire logic alarm_irq
);
    logic unmapped;
    assign unmapped = !(paddr[11:2] inside {10'h200, 10'h201, [10'h300:10'h304]});
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_DES_NO_RUN: assert property (des_mode |-> !osc_run)
        else $error("oscillators run in interleaved mode");
    AST_PD_NO_RUN: assert property (global_power_down |-> !osc_run)
        else $error("oscillators run in power-down");
    AST_PD_PIN: assert property (pd_pin |-> global_power_down)
        else $error("power-down pin ignored");
    AST_SYNC_CAUSE: assert property (osc_sync_pulse |->
        $past(sysref_pulse || ilas_start) || $past(sysref_pulse || ilas_start, 2))
        else $error("sync without event");
    AST_SYNC_RUN: assert property (osc_sync_pulse |-> $past(osc_run && serial_link_enable))
        else $error("sync while stopped");
    AST_SYNC_ONE: assert property (osc_sync_pulse |=> !osc_sync_pulse)
        else $error("sync pulse too long");
    // Alarm may only drop after a status clear or mask write
    AST_STICKY: assert property ($fell(alarm_irq) |->
        $past(psel && penable && pwrite && paddr[11:2] inside {10'h302, 10'h303}, 2))
        else $error("alarm dropped without host write");
    AST_ERR: assert property (psel && penable |-> pslverr == unmapped)
        else $error("slave error wrong");
    AST_RD_ZERO: assert property (psel && penable && !pwrite && unmapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind dud_top dud_upset_monitor mon (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .prdata,
    .pslverr, .sysref_pulse, .ilas_start, .pd_pin, .des_mode, .osc_run, .osc_sync_pulse,
    .serial_link_enable, .global_power_down, .alarm_irq);

// File: verif/dud_host_model.sv
/*
 * Host side: APB master issuing one transfer per call.
 * Assumes xfer is entered just after a rising edge of sys_clk.
 */
`timescale 1ns/100ps
module dud_host_model (
    input wire logic sys_clk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    // Ends with an idle cycle so back-to-back calls never retoggle psel in one step
    task automatic xfer(input logic [11:0] a, input logic [31:0] d, input logic w);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        while (pready !== 1'h1) @(posedge sys_clk);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask
endmodule

// File: verif/dud_top_tb.sv
/*
 * Self-checking bench for dud_top with default parameters.
 * Assumes the host model drives APB and the bench mirrors both channels.
 */
`timescale 1ns/100ps
module dud_top_tb;
    logic sys_clk, nrst = 1'h0, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [127:0] chan_a_phase_acc = '0, chan_b_phase_acc = '0, flip = '0, jump = '0;
    logic [7:0] chan_a_clk_state = '0, chan_b_clk_state = '0, cflip = '0, serial_format_mode;
    logic sysref_pulse = 1'h0, ilas_start = 1'h0, pd_pin = 1'h0, des_mode = 1'h0, cal_done = 1'h0;
    logic [1:0] chan_a_osc_select_pins, chan_b_osc_select_pins, chan_a_osc_sel, chan_b_osc_sel;
    logic osc_run, osc_sync_pulse, serial_link_enable, chan_a_power_down, chan_b_power_down;
    logic global_power_down, alarm_irq, cal_status_output;
    logic [32:0] expq[$];
    int n_mismatch = 0, num_checks = 0;

    dud_host_model host (.sys_clk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);
    dud_top uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .chan_a_phase_acc, .chan_b_phase_acc, .chan_a_clk_state, .chan_b_clk_state,
        .sysref_pulse, .ilas_start, .pd_pin, .des_mode, .cal_done, .chan_a_osc_select_pins,
        .chan_b_osc_select_pins, .chan_a_osc_sel, .chan_b_osc_sel, .osc_run, .osc_sync_pulse,
        .serial_link_enable, .serial_format_mode, .chan_a_power_down, .chan_b_power_down,
        .global_power_down, .alarm_irq, .cal_status_output);

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Channel B mirrors A; flip and cflip inject upsets, jump rewrites both words alike
    always @(posedge sys_clk) begin
        chan_a_phase_acc <= chan_a_phase_acc + 128'h1 + jump;
        chan_b_phase_acc <= (chan_a_phase_acc + 128'h1 + jump) ^ flip;
        chan_a_clk_state <= chan_a_clk_state + 8'h1;
        chan_b_clk_state <= (chan_a_clk_state + 8'h1) ^ cflip;
    end
    always @(posedge sys_clk) if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, expq.pop_front());
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        host.xfer(a, 32'h0, 1'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(a, d, 1'h1);
    endtask
    task automatic sync(input logic ilas, input logic hit);
        repeat (3) @(posedge sys_clk);
        if (ilas) ilas_start <= 1'h1;
        else sysref_pulse <= 1'h1;
        @(posedge sys_clk);
        ilas_start <= 1'h0;
        sysref_pulse <= 1'h0;
        @(posedge sys_clk);
        chk(33'(osc_sync_pulse), 33'(hit));
        @(posedge sys_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h0FC3));
        jump <= {$urandom, $urandom, $urandom, $urandom};
        chan_a_osc_select_pins <= 2'($urandom);
        chan_b_osc_select_pins <= 2'($urandom);
        @(posedge sys_clk);
        jump <= '0;
        repeat (9) @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge sys_clk);
        rd(12'h800, 33'h1);
        rd(12'h804, 33'h2);
        rd(12'hC00, 33'h0);
        rd(12'hC0C, 33'h0);
        wr(12'h808, 32'hFF);
        rd(12'h808, 33'h100000000);
        chk(33'({chan_b_osc_sel, chan_a_osc_sel}), 33'({chan_b_osc_select_pins, chan_a_osc_select_pins}));
        // Host bring-up order: link off, both up, DDC mode, link on, sync, clear
        wr(12'h800, 32'h0);
        wr(12'hC00, 32'h0);
        wr(12'h804, 32'h0A);
        wr(12'h800, 32'h1);
        sync(1'h0, 1'h1);
        chk(33'({serial_format_mode, serial_link_enable, chan_b_power_down, chan_a_power_down}), 33'h54);
        wr(12'hC08, 32'h3);
        rd(12'hC08, 33'h10);
        flip <= 128'h1 << ($urandom % 128);
        @(posedge sys_clk);
        flip <= '0;
        repeat (3) @(posedge sys_clk);
        chk(33'(alarm_irq), 33'h1);
        chk(33'(cal_status_output), 33'h0);
        rd(12'hC08, 33'h11);
        wr(12'hC00, 32'h20);
        repeat (2) @(posedge sys_clk);
        chk(33'(cal_status_output), 33'h1);
        wr(12'hC08, 32'h0);
        rd(12'hC08, 33'h11);
        flip <= 128'h1;
        wr(12'hC08, 32'h1);
        flip <= '0;
        rd(12'hC08, 33'h11);
        wr(12'hC08, 32'h1);
        rd(12'hC08, 33'h10);
        cflip <= 8'h80;
        repeat (2) @(posedge sys_clk);
        cflip <= '0;
        rd(12'hC08, 33'h12);
        wr(12'hC0C, 32'h2);
        rd(12'hC10, 33'h0);
        chk(33'(alarm_irq), 33'h0);
        wr(12'hC0C, 32'h0);
        rd(12'hC10, 33'h1);
        wr(12'hC08, 32'h2);
        rd(12'hC08, 33'h10);
        wr(12'hC04, 32'hD);
        wr(12'hC00, 32'h10);
        repeat (2) @(posedge sys_clk);
        chk(33'({chan_b_osc_sel, chan_a_osc_sel}), 33'hD);
        des_mode <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk(33'(osc_run), 33'h0);
        rd(12'hC08, 33'h0);
        des_mode <= 1'h0;
        wr(12'hC00, 32'h7);
        chk(33'({global_power_down, chan_b_power_down, chan_a_power_down, osc_run}), 33'hE);
        wr(12'hC00, 32'h8);
        sync(1'h0, 1'h0);
        rd(12'hC08, 33'h0);
        sync(1'h1, 1'h1);
        rd(12'hC08, 33'h10);
        pd_pin <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk(33'(global_power_down), 33'h1);
        pd_pin <= 1'h0;
        // New words while running: resync, clear, monitor again
        jump <= {$urandom, $urandom, $urandom, $urandom};
        @(posedge sys_clk);
        jump <= '0;
        sync(1'h1, 1'h1);
        wr(12'hC08, 32'h3);
        rd(12'hC08, 33'h10);
        // Reset in mid-run must drop sync, alarms and mode back to idle
        nrst <= 1'h0;
        @(posedge sys_clk);
        nrst <= 1'h1;
        repeat (3) @(posedge sys_clk);
        rd(12'hC08, 33'h0);
        rd(12'h804, 33'h2);
        complete_run;
    end
endmodule
